// >>> opctl_cfg.svh
`ifndef OPCTL_CFG_SVH
`define OPCTL_CFG_SVH

// ===================== parameter indices
`define IDX_DIR 2'h0
`define IDX_LANG 2'h1
`define IDX_DMODE 2'h2
`define IDX_STEP 2'h3
// ===================== reset values
`define RST_DIR 16'h0000
`define RST_LANG 16'h0001
`define RST_DMODE 16'h0000
`define RST_STEP 16'h0000
// ===================== encodings (frequency in 0.01 Hz)
`define LANG_MAX 16'h0007
`define DMODE_POT_LOCK 16'h000b
`define DMODE_STEP_LOCK 16'h000a
`define DMODE_POT 16'h0001
`define STEP_MIN_HI 16'h000a
`define FREQ_HI 16'h2710
`define CLICKS_PER_TURN 5'h18
// ===================== timing
`define CLK_MHZ 100
`define FLASH_MS 5000
`define STORE_MS 10000
`define HOLD_MS 2000
`define IND_MS 2000
`define MS_CYC (`CLK_MHZ * 1000)
`endif

// >>> opctl_pkg.sv
package opctl_pkg;
  typedef struct packed {
    logic run;
    logic stop;
    logic mode;
    logic set;
    logic click;
    logic ccw;
  } panel_in_type;
  typedef struct packed {
    logic we;
    logic [1:0] idx;
    logic [15:0] data;
  } prm_wr_type;
  typedef enum logic {UNLOCKED, LOCKED} lock_type;
endpackage

// >>> operation_panel_input_control.sv
`timescale 1ns/1ps
`include "opctl_cfg.svh"
module operation_panel_input_control #(
  parameter int unsigned FLASH_CYC = `FLASH_MS * `MS_CYC,
  parameter int unsigned STORE_CYC = `STORE_MS * `MS_CYC,
  parameter int unsigned HOLD_CYC = `HOLD_MS * `MS_CYC,
  parameter int unsigned IND_CYC = `IND_MS * `MS_CYC,
  parameter logic [15:0] FREQ_MAX = 16'h9c40
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input opctl_pkg::panel_in_type i_pins,
  input opctl_pkg::prm_wr_type i_prm,
  output logic [15:0] o_dir_sel,
  output logic [15:0] o_lang_sel,
  output logic [15:0] o_dmode_sel,
  output logic [15:0] o_step_sel,
  output logic o_run,
  output logic o_reverse,
  output logic o_panel_stop,
  output logic [15:0] o_set_freq,
  output logic [15:0] o_entry_freq,
  output logic o_flash,
  output logic o_locked,
  output logic o_lock_ind,
  output logic [4:0] o_dial_pos,
  output logic o_nvm_store,
  output logic [15:0] o_nvm_freq
);
  import opctl_pkg::*;

  typedef struct packed {
    panel_in_type s1;
    panel_in_type s2;
    panel_in_type s3;
    panel_in_type f;
    logic [15:0] dir;
    logic [15:0] lang;
    logic [15:0] dmode;
    logic [15:0] step;
    logic run;
    logic rev;
    logic pstop;
    logic [15:0] freq;
    logic [15:0] pend;
    logic flash;
    logic [31:0] flash_cnt;
    lock_type lock;
    logic [31:0] hold_cnt;
    logic hold_done;
    logic ind;
    logic [31:0] ind_cnt;
    logic [4:0] pos;
    logic dirty;
    logic [31:0] store_cnt;
    logic store;
    logic [15:0] nvm;
  } state_type;

  state_type st_r, st_nxt;

  // ===================== helpers
  function automatic logic valid_step(input logic [15:0] v);
    valid_step = (v == 16'h0000) || (v == 16'h0001) || (v == 16'h000a)
      || (v == 16'h0064) || (v == 16'h03e8);
  endfunction

  function automatic logic [15:0] step_of(input logic [15:0] sel,
                                          input logic [15:0] fq);
    logic [15:0] s;
    s = (sel == 16'h0000) ? 16'h0001 : sel;
    if (fq >= `FREQ_HI && s < `STEP_MIN_HI)
      s = `STEP_MIN_HI;
    step_of = s;
  endfunction

  function automatic logic [15:0] apply(input logic [15:0] fq,
                                        input logic [15:0] s,
                                        input logic down);
    logic [16:0] sum;
    sum = {1'b0, fq} + {1'b0, s};
    if (down)
      apply = (fq > s) ? fq - s : 16'h0000;
    else
      apply = (sum > {1'b0, FREQ_MAX}) ? FREQ_MAX : sum[15:0];
  endfunction

  function automatic logic lock_mode(input logic [15:0] m);
    lock_mode = (m == `DMODE_STEP_LOCK) || (m == `DMODE_POT_LOCK);
  endfunction

  // ===================== next state
  panel_in_type edge_w;
  logic pot_w;
  logic [15:0] step_w;

  always_comb begin
    st_nxt = st_r;
    // three-stage sync; level accepted once stages two and three agree
    st_nxt.s1 = i_pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < $bits(panel_in_type); i++) begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.f[i] = st_r.s3[i];
    end
    edge_w = st_nxt.f & ~st_r.f;
    edge_w.ccw = 1'b0;
    pot_w = (st_r.dmode == `DMODE_POT) || (st_r.dmode == `DMODE_POT_LOCK);
    step_w = step_of(st_r.step, st_r.pend);
    st_nxt.store = 1'b0;

    // writes filtered to legal settings
    if (i_prm.we) begin
      case (i_prm.idx)
        `IDX_DIR: if (i_prm.data <= 16'h0001) st_nxt.dir = i_prm.data;
        `IDX_LANG: if (i_prm.data <= `LANG_MAX)
          st_nxt.lang = i_prm.data;
        `IDX_DMODE: if (i_prm.data <= 16'h0001 || lock_mode(i_prm.data))
          st_nxt.dmode = i_prm.data;
        `IDX_STEP: if (valid_step(i_prm.data)) st_nxt.step = i_prm.data;
        default: st_nxt.dir = st_r.dir;
      endcase
    end

    // stop is honoured whatever the lock
    if (edge_w.stop) begin
      st_nxt.run = 1'b0;
      st_nxt.pstop = 1'b1;
    end

    // mode key hold toggles the lock once per press
    if (!st_r.f.mode) begin
      st_nxt.hold_cnt = 32'h0000_0000;
      st_nxt.hold_done = 1'b0;
    end else if (!st_r.hold_done) begin
      if (st_r.hold_cnt >= 32'(HOLD_CYC - 1)) begin
        st_nxt.hold_done = 1'b1;
        if (st_r.lock == LOCKED) begin
          st_nxt.lock = UNLOCKED;
          st_nxt.ind = 1'b0;
        end else if (lock_mode(st_r.dmode)) begin
          st_nxt.lock = LOCKED;
        end
      end else begin
        st_nxt.hold_cnt = st_r.hold_cnt + 32'h0000_0001;
      end
    end
    if (!lock_mode(st_r.dmode))
      st_nxt.lock = UNLOCKED;

    if (st_r.lock == LOCKED) begin
      // indication only; the action itself is dropped
      if (edge_w.run || edge_w.mode || edge_w.set || edge_w.click) begin
        st_nxt.ind = 1'b1;
        st_nxt.ind_cnt = 32'h0000_0000;
      end else if (st_r.ind) begin
        if (st_r.ind_cnt >= 32'(IND_CYC - 1))
          st_nxt.ind = 1'b0;
        else
          st_nxt.ind_cnt = st_r.ind_cnt + 32'h0000_0001;
      end
    end else begin
      st_nxt.ind = 1'b0;
      if (edge_w.run && !edge_w.stop) begin
        st_nxt.run = 1'b1;
        st_nxt.pstop = 1'b0;
        st_nxt.rev = st_r.dir[0];
      end
      if (edge_w.click) begin
        st_nxt.pos = (st_r.pos == `CLICKS_PER_TURN - 5'h01) ? 5'h00 :
          st_r.pos + 5'h01;
        if (st_r.f.ccw)
          st_nxt.pos = (st_r.pos == 5'h00) ? `CLICKS_PER_TURN - 5'h01 :
            st_r.pos - 5'h01;
        st_nxt.pend = apply(st_r.pend, step_w, st_r.f.ccw);
        if (pot_w) begin
          st_nxt.freq = st_nxt.pend;
          st_nxt.flash = 1'b1;
          st_nxt.flash_cnt = 32'h0000_0000;
        end
      end
      if (edge_w.set && !pot_w)
        st_nxt.freq = st_r.pend;
    end
    if (!pot_w && st_r.lock == UNLOCKED && edge_w.mode)
      st_nxt.pend = st_r.freq;

    // flash timeout
    if (st_r.flash && !(st_nxt.flash_cnt == 32'h0000_0000 &&
        st_r.flash_cnt != 32'h0000_0000)) begin
      if (st_r.flash_cnt >= 32'(FLASH_CYC - 1))
        st_nxt.flash = 1'b0;
      else if (st_nxt.flash_cnt != 32'h0000_0000 || !edge_w.click)
        st_nxt.flash_cnt = st_r.flash_cnt + 32'h0000_0001;
    end

    // delayed nvm write; each change restarts the wait
    if (st_nxt.freq != st_r.freq) begin
      st_nxt.dirty = 1'b1;
      st_nxt.store_cnt = 32'h0000_0000;
    end else if (st_r.dirty) begin
      if (st_r.store_cnt >= 32'(STORE_CYC - 1)) begin
        st_nxt.dirty = 1'b0;
        st_nxt.store = 1'b1;
        st_nxt.nvm = st_r.freq;
      end else begin
        st_nxt.store_cnt = st_r.store_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.dir <= `RST_DIR;
      st_r.lang <= `RST_LANG;
      st_r.dmode <= `RST_DMODE;
      st_r.step <= `RST_STEP;
      st_r.lock <= UNLOCKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===================== outputs
  assign o_dir_sel = st_r.dir;
  assign o_lang_sel = st_r.lang;
  assign o_dmode_sel = st_r.dmode;
  assign o_step_sel = st_r.step;
  assign o_run = st_r.run;
  assign o_reverse = st_r.rev;
  assign o_panel_stop = st_r.pstop;
  assign o_set_freq = st_r.freq;
  assign o_entry_freq = st_r.pend;
  assign o_flash = st_r.flash;
  assign o_locked = st_r.lock;
  assign o_lock_ind = st_r.ind;
  assign o_dial_pos = st_r.pos;
  assign o_nvm_store = st_r.store;
  assign o_nvm_freq = st_r.nvm;

  // ===================== checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence pot_click_s;
    edge_w.click && pot_w && st_r.lock == UNLOCKED;
  endsequence
  sequence locked_key_s;
    st_r.lock == LOCKED && (edge_w.run || edge_w.set || edge_w.click);
  endsequence
  // a mode edge reloads the entry value, so it is kept out of step checks
  sequence free_click_s;
    edge_w.click && st_r.lock == UNLOCKED && !edge_w.mode;
  endsequence

  run_dir_a: assert property (
    $rose(st_r.run) |-> st_r.rev == st_r.dir[0])
    else $error("run direction differs from setting");
  lang_range_a: assert property (
    st_r.lang <= `LANG_MAX)
    else $error("language code out of range");
  lock_entry_a: assert property (
    $rose(o_locked) |-> lock_mode(st_r.dmode) && $past(st_r.f.mode))
    else $error("lock without lock mode");
  lock_exit_a: assert property (
    $fell(o_locked) && lock_mode(st_r.dmode) |-> $past(st_r.f.mode))
    else $error("lock released without mode key");
  dial_frozen_a: assert property (
    st_r.lock == LOCKED |=> st_r.freq == $past(st_r.freq))
    else $error("frequency moved while locked");
  pot_update_a: assert property (
    pot_click_s |=> st_r.freq == st_r.pend && st_r.flash)
    else $error("pot dial did not set");
  stop_always_a: assert property (
    edge_w.stop |=> !st_r.run && st_r.pstop)
    else $error("stop key ignored");
  lock_ind_a: assert property (
    locked_key_s |=> st_r.ind)
    else $error("no lock indication");
  ind_clear_a: assert property (
    st_r.lock == UNLOCKED |=> !st_r.ind)
    else $error("lock indication while unlocked");
  locked_run_a: assert property (
    locked_key_s ##0 st_r.pstop |=> st_r.pstop)
    else $error("panel stop released while locked");
  step_fine_a: assert property (
    free_click_s ##0 st_r.step == 16'h0000 && !st_r.f.ccw &&
    st_r.pend < `FREQ_HI && st_r.pend < FREQ_MAX |=>
    st_r.pend == $past(st_r.pend) + 16'h0001)
    else $error("default step is not 0.01 Hz");
  // clear of the clamp at either end so the full step must show
  step_min_a: assert property (
    free_click_s ##0 st_r.pend >= `FREQ_HI &&
    st_r.pend <= FREQ_MAX - 16'h03e8 |=>
    ((st_r.pend > $past(st_r.pend)) ? st_r.pend - $past(st_r.pend) :
    $past(st_r.pend) - st_r.pend) >= `STEP_MIN_HI)
    else $error("step below 0.1 Hz");
  click_move_a: assert property (
    free_click_s |=> st_r.pos != $past(st_r.pos))
    else $error("dial click not counted");
  click_pos_a: assert property (
    free_click_s ##0 !st_r.f.ccw ##0 st_r.pos == 5'h17 |=>
    st_r.pos == 5'h00)
    else $error("dial position wrap wrong");
  store_pulse_a: assert property (
    st_r.store |-> o_nvm_freq == st_r.freq ##1 !st_r.store)
    else $error("nvm store pulse wrong");

endmodule // operation_panel_input_control

// >>> operation_panel_input_control_test.sv
`timescale 1ns/1ps
// ===================== bench
module operation_panel_input_control_test;
  import opctl_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned IND = 20;
  localparam int unsigned STORE = 100;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  panel_in_type pins;
  prm_wr_type parameter_indicator;
  logic [15:0] dir, lang, dmode, step, setf, entf, nvmf, f;
  logic run, rev, pstop, flash, locked, ind, store;
  logic [4:0] pos;
  logic [31:0] lfsr = 32'h6d3d5d5e;
  logic [15:0] modes[4] = '{16'h0000, 16'h0001, 16'h000a, 16'h000b};
  logic [19:0] q[$];
  int fails = 0;
  int n_checks = 0;
  int n;
  int k;
  always #5 i_clk = ~i_clk;
  panel_operator op (.i_clk(i_clk), .o_pins(pins));
  operation_panel_input_control #(.FLASH_CYC(50), .STORE_CYC(STORE),
    .HOLD_CYC(HOLD), .IND_CYC(IND)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_pins(pins), .i_prm(parameter_indicator),
    .o_dir_sel(dir), .o_lang_sel(lang), .o_dmode_sel(dmode),
    .o_step_sel(step), .o_run(run), .o_reverse(rev),
    .o_panel_stop(pstop), .o_set_freq(setf), .o_entry_freq(entf),
    .o_flash(flash), .o_locked(locked), .o_lock_ind(ind),
    .o_dial_pos(pos), .o_nvm_store(store), .o_nvm_freq(nvmf));
  function automatic logic [15:0] pick(input logic [3:0] w);
    case (w)
      4'h0: return dir;
      4'h1: return lang;
      4'h2: return dmode;
      4'h3: return step;
      4'h4: return setf;
      4'h5: return entf;
      4'h6: return nvmf;
      4'h7: return {11'h000, pos};
      4'h8: return {15'h0000, run};
      4'h9: return {15'h0000, rev};
      4'ha: return {15'h0000, pstop};
      4'hb: return {15'h0000, flash};
      4'hc: return {15'h0000, locked};
      4'hd: return {15'h0000, ind};
      default: return {15'h0000, store};
    endcase
  endfunction
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic note(input logic [3:0] w, input logic [15:0] v);
    q.push_back({w, v});
  endtask
  task automatic wr(input logic [1:0] x, input logic [15:0] d);
    @(posedge i_clk) #1 parameter_indicator = '{we: 1'b1, idx: x, data: d};
    @(posedge i_clk) #1 parameter_indicator.we = 1'b0;
    @(posedge i_clk) #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read mid-cycle, well clear of the edge that moves the outputs
  always @(negedge i_clk) begin
    while (q.size() > 0) begin
      cmp(pick(q[0][19:16]), q[0][15:0]);
      void'(q.pop_front());
    end
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    // random keys and a write under reset: reset must outweigh both
    f = rnd();
    parameter_indicator = '{we: 1'b1, idx: lfsr[3:2], data: f};
    op.hold_all(panel_in_type'(lfsr[13:8]));
    repeat (15) @(posedge i_clk);
    #1 parameter_indicator = '0;
    op.hold_all('0);
    @(posedge i_clk) #1 i_resetn = 1'b1;
    note(4'h0, 16'h0000);
    note(4'h1, 16'h0001);
    note(4'h2, 16'h0000);
    note(4'h3, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(2'h1, 16'(i));
      note(4'h1, 16'(i));
    end
    wr(2'h1, rnd() | 16'h0008);
    note(4'h1, 16'h0007);
    wr(2'h0, rnd() | 16'h0002);
    note(4'h0, 16'h0000);
    foreach (modes[i]) begin
      wr(2'h2, modes[i]);
      note(4'h2, modes[i]);
    end
    wr(2'h2, rnd() | 16'h0100);
    note(4'h2, 16'h000b);
    wr(2'h2, 16'h0000);
    f = (rnd() & 16'h0003) + 16'h0001;
    n = int'(f);
    repeat (n) op.turn(1'b0);
    note(4'h5, f);
    note(4'h4, 16'h0000);
    op.press(2, 4);
    note(4'h4, f);
    wr(2'h3, 16'h0001);
    wr(2'h3, rnd() | 16'h8000);
    note(4'h3, 16'h0001);
    repeat (24) op.turn(1'b0);
    f = f + 16'h0018;
    note(4'h7, 16'(n));
    wr(2'h3, 16'h0064);
    op.turn(1'b0);
    note(4'h5, f + 16'h0064);
    op.turn(1'b1);
    note(4'h5, f);
    wr(2'h3, 16'h03e8);
    repeat (10) op.turn(1'b0);
    wr(2'h3, 16'h0001);
    op.turn(1'b0);
    f = f + 16'h2710 + 16'h000a;
    note(4'h5, f);
    op.press(2, 4);
    wr(2'h2, 16'h0001);
    op.turn(1'b0);
    f = f + 16'h000a;
    note(4'h4, f);
    note(4'hb, 16'h0001);
    k = 0;
    while (store !== 1'b1 && k < STORE + 40) begin
      @(posedge i_clk) #1;
      k++;
    end
    cmp(16'(k > STORE - 20 && k < STORE), 16'h0001);
    note(4'he, 16'h0001);
    note(4'h6, f);
    note(4'hb, 16'h0000);
    wr(2'h0, 16'h0001);
    note(4'h0, 16'h0001);
    op.press(5, 4);
    note(4'h9, 16'h0001);
    note(4'h8, 16'h0001);
    op.press(4, 4);
    note(4'ha, 16'h0001);
    wr(2'h0, 16'h0000);
    op.press(5, 4);
    note(4'h9, 16'h0000);
    note(4'ha, 16'h0000);
    wr(2'h2, 16'h000a);
    op.press(3, HOLD + 10);
    note(4'hc, 16'h0001);
    op.turn(1'b0);
    note(4'hd, 16'h0001);
    note(4'h5, f);
    op.press(4, 4);
    note(4'h8, 16'h0000);
    op.press(5, 4);
    note(4'ha, 16'h0001);
    repeat (IND + 4) @(posedge i_clk);
    note(4'hd, 16'h0000);
    op.press(3, HOLD + 10);
    note(4'hc, 16'h0000);
    op.press(5, 4);
    note(4'ha, 16'h0000);
    repeat (2) @(posedge i_clk);
    print_verdict();
  end
endmodule // operation_panel_input_control_test

// >>> panel_operator.sv
`timescale 1ns/1ps
// ===================== operator at the panel
module panel_operator (
  input wire logic i_clk,
  output opctl_pkg::panel_in_type o_pins
);
  import opctl_pkg::*;
  // every key at once; random levels are set under reset, idle before release
  task automatic hold_all(input panel_in_type v);
    o_pins = v;
  endtask
  // a human holds a key for n cycles, then leaves the panel idle a while
  task automatic press(input int bit_no, input int n);
    @(posedge i_clk) #1 o_pins[bit_no] = 1'b1;
    repeat (n) @(posedge i_clk);
    #1 o_pins[bit_no] = 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  // direction is set first so the click samples a settled level
  task automatic turn(input logic down);
    @(posedge i_clk) #1 o_pins.ccw = down;
    press(1, 4);
  endtask
endmodule // panel_operator
